// ===== asrc_host.sv
// What this block does
// - address changes only while write strobe or select is high.
// - with output enable low, strobe width covers float plus data setup.
// - with output enable high, ordinary write_pulse_width suffices.
// - host never drives data while memory may still drive it.
// - address valid no later than select falling edge for reads.
// - write strobe stays high throughout every read.
`timescale 1ns/100ps
`default_nettype none

module asrc_host
  import asrc_pkg::*;
#(
  parameter int ACCESS_CYCLES = ACC_CYC
)
(
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  // user request side
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire asrc_req_t         req,
  output logic [DATA_W-1:0]      rsp_rdata,
  output logic                   rsp_rvalid,
  output logic                   rsp_wdone,
  // memory pins
  output logic                   mem_sel_n,
  output logic                   mem_oe_n,
  output logic                   mem_we_n,
  output logic [ADDR_W-1:0]      mem_addr,
  input  wire logic [DATA_W-1:0] mem_dq_in,
  output logic [DATA_W-1:0]      mem_dq_out,
  output logic                   mem_dq_oe_n
);

  // the counter holds at most 15; a longer wait would wrap silently
  if (ACCESS_CYCLES < 1 || ACCESS_CYCLES > 15)
  begin : g_bad_access
    $error("ACCESS_CYCLES out of range");
  end

  asrc_regs_t r;
  asrc_regs_t next_r;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------

  // accepting only in idle keeps each access a whole, ordered cycle
  assign req_ready = (r.state == ST_IDLE);

  // one combinational copy of the whole state
  always_comb
  begin
    next_r = r;
    next_r.rvalid = 1'b0;
    next_r.wdone = 1'b0;
    unique case (r.state)
      ST_IDLE:
      begin
        next_r.pins = PINS_IDLE;
        if (req_valid)
        begin
          // address settles while deselected and strobe high
          next_r.pins.addr = req.addr;
          next_r.pins.dq_out = req.wdata;
          next_r.state = ST_SETUP;
          next_r.pins.we_n = 1'b1;
          // oe stays high; the write flag rides in the counter
          next_r.pins.oe_n = 1'b1;
          next_r.cnt = req.write ? CNT_W'(1) : CNT_W'(0);
        end
      end
      ST_SETUP:
      begin
        next_r.pins.sel_n = 1'b0;
        if (r.cnt == CNT_W'(1))
        begin
          // strobe falls with select; memory outputs never turn on
          next_r.pins.we_n = 1'b0;
          // oe held high, so we can drive at once and use plain width;
          // an oe-low write would need the float-plus-setup length
          next_r.pins.dq_oe_n = 1'b0;
          next_r.cnt = r.pins.oe_n ? CNT_W'(WP_CYC)
                                   : CNT_W'(WP_OE_CYC);
          next_r.state = ST_WRITE;
        end
        else
        begin
          next_r.pins.oe_n = 1'b0;
          next_r.pins.we_n = 1'b1;
          next_r.cnt = CNT_W'(ACCESS_CYCLES);
          next_r.state = ST_READ;
        end
      end
      ST_WRITE:
      begin
        // whole word stored during the overlap of select and strobe
        if (r.cnt == CNT_W'(1))
        begin
          next_r.pins.we_n = 1'b1;
          next_r.pins.sel_n = 1'b1;
          next_r.wdone = 1'b1;
          next_r.state = ST_IDLE;
        end
        else
        begin
          next_r.cnt = r.cnt - CNT_W'(1);
        end
      end
      ST_READ:
      begin
        if (r.cnt == CNT_W'(1))
        begin
          next_r.rdata = mem_dq_in;
          next_r.rvalid = 1'b1;
          next_r.pins.oe_n = 1'b1;
          next_r.pins.sel_n = 1'b1;
          next_r.cnt = CNT_W'(FLOAT_CYC);
          next_r.state = ST_FLOAT;
        end
        else
        begin
          next_r.cnt = r.cnt - CNT_W'(1);
        end
      end
      ST_FLOAT:
      begin
        // memory needs time to release the bus before next write
        if (r.cnt == CNT_W'(1))
          next_r.state = ST_IDLE;
        else
          next_r.cnt = r.cnt - CNT_W'(1);
      end
    endcase
  end

  // state register; clockless memory needs no refresh traffic
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      r.state <= ST_IDLE;
      r.pins <= PINS_IDLE;
      r.cnt <= '0;
      r.rdata <= '0;
      r.rvalid <= 1'b0;
      r.wdone <= 1'b0;
    end
    else
      r <= next_r;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign mem_sel_n = r.pins.sel_n;
  assign mem_oe_n = r.pins.oe_n;
  assign mem_we_n = r.pins.we_n;
  assign mem_addr = r.pins.addr;
  assign mem_dq_out = r.pins.dq_out;
  assign mem_dq_oe_n = r.pins.dq_oe_n;
  assign rsp_rdata = r.rdata;
  assign rsp_rvalid = r.rvalid;
  assign rsp_wdone = r.wdone;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_addr_stable_sel: assert property (@(posedge clock) disable iff (!rst_n)
    $changed(mem_addr) |-> (mem_we_n || mem_sel_n))
    else $error("address moved during active write");

  a_idle_deselect: assert property (@(posedge clock) disable iff (!rst_n)
    (r.state == ST_IDLE) |-> (mem_sel_n && (mem_dq_oe_n || rsp_wdone)))
    else $error("idle but selected or driving");

  a_read_we_high: assert property (@(posedge clock) disable iff (!rst_n)
    !mem_oe_n |-> mem_we_n)
    else $error("strobe low during read");

  a_no_contention: assert property (@(posedge clock) disable iff (!rst_n)
    !mem_dq_oe_n |-> mem_oe_n)
    else $error("host drives while memory may drive");

  a_write_width: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(mem_we_n) |-> !mem_we_n [*2])
    else $error("write pulse too short");

  a_we_with_sel: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(mem_we_n) |-> $fell(mem_sel_n) || !$past(mem_sel_n))
    else $error("strobe fell before select");

  a_read_wait: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(mem_oe_n) |-> !mem_oe_n [*2] ##1 rsp_rvalid)
    else $error("read data taken before access delay");

  a_write_done: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(mem_we_n) |-> rsp_wdone)
    else $error("write end not reported");

  a_data_release: assert property (@(posedge clock) disable iff (!rst_n)
    rsp_wdone |=> mem_dq_oe_n)
    else $error("write data held past the hold cycle");

  a_sel_addr_settled: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(mem_sel_n) |-> $stable(mem_addr))
    else $error("address moved as select fell");

  a_write_data_on: assert property (@(posedge clock) disable iff (!rst_n)
    !mem_we_n |-> !mem_dq_oe_n)
    else $error("strobe low without write data driven");

endmodule : asrc_host

`default_nettype wire

// ===== asrc_pkg.sv
package asrc_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 18;
  localparam int DATA_W = 4;

  // ----------------------------------------------------------------
  // timing (ns as printed, cycles derived from the 8 ns clock)
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int T_WRITE_PULSE_WIDTH_NS = 12;
  localparam int T_WRITE_TO_FLOAT_DELAY_NS = 7;
  localparam int T_DATA_SETUP_TO_WRITE_END_NS = 8;
  localparam int T_ADDRESS_ACCESS_DELAY_NS = 15;
  localparam int T_OUTPUT_FLOAT_NS = 7;
  // least times round up, never below one cycle
  localparam int WP_CYC = (T_WRITE_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1)
                          / CLK_PERIOD_NS;
  localparam int WP_OE_CYC = (T_WRITE_TO_FLOAT_DELAY_NS
                              + T_DATA_SETUP_TO_WRITE_END_NS
                              + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACC_CYC = (T_ADDRESS_ACCESS_DELAY_NS + CLK_PERIOD_NS - 1)
                           / CLK_PERIOD_NS;
  localparam int FLOAT_CYC = (T_OUTPUT_FLOAT_NS + CLK_PERIOD_NS - 1)
                             / CLK_PERIOD_NS;
  localparam int CNT_W = 4;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asrc_req_t;

  typedef struct packed {
    logic              sel_n;
    logic              oe_n;
    logic              we_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic              dq_oe_n;
  } asrc_pins_t;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_SETUP  = 5'h02,
    ST_WRITE  = 5'h04,
    ST_READ   = 5'h08,
    ST_FLOAT  = 5'h10
  } asrc_state_t;

  typedef struct packed {
    asrc_state_t       state;
    asrc_pins_t        pins;
    logic [CNT_W-1:0]  cnt;
    logic [DATA_W-1:0] rdata;
    logic              rvalid;
    logic              wdone;
  } asrc_regs_t;

  localparam asrc_pins_t PINS_IDLE = '{sel_n: 1'b1, oe_n: 1'b1,
                                       we_n: 1'b1, addr: '0,
                                       dq_out: '0, dq_oe_n: 1'b1};

endpackage : asrc_pkg

// ===== asrc_sram_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// static memory as seen at its pins
// ----------------------------------------
module asrc_sram_model
  import asrc_pkg::*;
#(
  parameter int ACC_NS = T_ADDRESS_ACCESS_DELAY_NS
)
(
  // controls, active low
  input  wire logic              sel_n,
  input  wire logic              oe_n,
  input  wire logic              we_n,
  // address and data lines
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] dq,
  output logic [DATA_W-1:0]      q,
  output logic                   q_on
);
  // sparse word store, kept with no clock and no refresh
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  initial q = 4'h0;
  // drives only when selected, enabled and not writing
  assign q_on = !sel_n && !oe_n && we_n;
  // whole word taken while select and strobe overlap
  always @(sel_n, we_n, addr, dq)
    if (!sel_n && !we_n)
      mem[addr] = dq;
  // stale lines until access time runs out, so early samples fail
  always @(addr, q_on)
  begin
    q = ~q;
    q <= #ACC_NS (mem.exists(addr) ? mem[addr] : ~q);
  end
endmodule : asrc_sram_model
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// bench: host port against the memory model
// ----------------------------------------
module tb_top
  import asrc_pkg::*;
;
  logic              clock, rst_n, req_valid, req_ready, rvalid, wdone;
  logic              sel_n, oe_n, we_n, dq_oe_n, q_on, prv_sel, prv_we;
  logic [ADDR_W-1:0] addr, prv_addr, cur_addr;
  logic [DATA_W-1:0] rdata, dq_out, q, dq, flt;
  logic [31:0]       r;
  asrc_req_t         req;
  int                n_mismatch, checks_done, seed, wlen;
  logic [DATA_W-1:0] ref_mem [int];

  // no pull on the lines: a released bus shows a changing pattern
  assign dq = !dq_oe_n ? dq_out : q_on ? q : flt;
  always @(posedge clock)
    flt <= ~dq;

  asrc_host #(.ACCESS_CYCLES(ACC_CYC)) u_asrc_host (.clock(clock),
    .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .rsp_rdata(rdata), .rsp_rvalid(rvalid), .rsp_wdone(wdone),
    .mem_sel_n(sel_n), .mem_oe_n(oe_n), .mem_we_n(we_n), .mem_addr(addr),
    .mem_dq_in(dq), .mem_dq_out(dq_out), .mem_dq_oe_n(dq_oe_n));
  asrc_sram_model u_asrc_sram_model (.sel_n(sel_n), .oe_n(oe_n),
    .we_n(we_n), .addr(addr), .dq(dq), .q(q), .q_on(q_on));

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run

  task automatic cmp_word(input string nm, input logic [ADDR_W-1:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_word

  task automatic cmp_flag(input string nm, input logic e, g);
    cmp_word(nm, ADDR_W'(e), ADDR_W'(g));
  endtask : cmp_flag

  // a used-up wait ends the run at once
  task automatic bound(input int n);
    if (n >= 20)
    begin
      n_mismatch++;
      complete_run();
    end
  endtask : bound

  // one request, driven at the falling edge, answer checked by count
  task automatic do_op(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    req_valid = 1'b1;
    req = '{write: wr, addr: a, wdata: d};
    cur_addr = a;
    while (req_ready !== 1'b1 && n < 20)
    begin
      @(negedge clock);
      n++;
    end
    bound(n);
    @(negedge clock);
    req_valid = 1'b0;
    n = 1;
    while ((wr ? wdone : rvalid) !== 1'b1 && n < 20)
    begin
      @(negedge clock);
      n++;
    end
    bound(n);
    cmp_word("latency", ADDR_W'(wr ? WP_CYC + 2 : ACC_CYC + 2), ADDR_W'(n));
    cmp_flag("sel_idle", 1'b1, sel_n);
    if (wr)
      ref_mem[a] = d;
    else
      cmp_word("rdata", ADDR_W'(ref_mem[a]), ADDR_W'(rdata));
  endtask : do_op

  // pin watch on settled levels, between clock edges
  always @(negedge clock)
  begin
    if (rst_n)
    begin
      if (addr !== prv_addr)
        cmp_flag("addr_move", 1'b1, (sel_n|we_n) & (prv_sel|prv_we));
      if (!oe_n)
        cmp_flag("we_in_read", 1'b1, we_n);
      if (!dq_oe_n)
        cmp_flag("contention", 1'b0, q_on);
      if (!sel_n && prv_sel)
        cmp_word("sel_addr", cur_addr, addr);
      if (we_n && !prv_we)
        cmp_flag("we_width", 1'b1, wlen >= WP_CYC);
    end
    wlen = we_n ? 0 : wlen + 1;
    prv_sel = sel_n;
    prv_we = we_n;
    prv_addr = addr;
  end

  initial
  begin
    seed = 32'hA849B703;
    {n_mismatch, checks_done, wlen} = '0;
    {rst_n, req_valid, req, flt} = '0;
    {prv_sel, prv_we, prv_addr, cur_addr} = '1;
    repeat (2) @(negedge clock);
    // controls parked high, memory in standby
    cmp_word("reset_pins", 18'h0003F, {sel_n, oe_n, we_n, dq_oe_n,
             req_ready, 1'b1} | addr);
    rst_n = 1'b1;
    // extreme words, overwrite, then back to back reads
    do_op(1'b1, 18'h00000, 4'hA);
    do_op(1'b1, 18'h3FFFF, 4'h5);
    do_op(1'b1, 18'h3FFFF, 4'hC);
    do_op(1'b0, 18'h3FFFF, 4'h0);
    do_op(1'b0, 18'h00000, 4'h0);
    // mid-run reset between accesses: pins park again, store is kept
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    cmp_word("reset_pins", 18'h0003F, {sel_n, oe_n, we_n, dq_oe_n,
             req_ready, 1'b1} | addr);
    rst_n = 1'b1;
    // random mix over a small set of words so reads hit writes
    repeat (60)
    begin
      r = $random(seed);
      do_op(r[31] || !ref_mem.exists(r[17:0] & 18'h3000F),
            r[17:0] & 18'h3000F, r[25:22]);
    end
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
